/* File: core/sacr_control.v */
// Control, conversion sequencer and three-state readout of a 12-bit SAR converter
`timescale 1ns/1ps
// Notes on behaviour
// - Stand-alone data readable while read/convert high and status low.
// - Status high only while a conversion is active.
// - All data buffers released while status is high.
// - Start conditions during a conversion are ignored.
// - Byte address latched at start: low means 12 bits, high means 8.
// - After 8-bit conversion the low three bits read zero, bit three one.
// - Only byte address is latched; other controls act on live levels.
// - Start when enable high, select low, read/convert low; last one triggers.
// - Same start delay from any input; simultaneous change also starts.
// - Outputs float until read high, status low, enable high, select low.
// - Word select high drives all twelve lines, byte address ignored.
// - Byte mode: high byte on eight MSB lines, or low nibble plus zeros.
// - Byte switching breaks one driver set before making the other.
`include "sacr_defines.vh"
module sacr_control
(
  input wire clk,
  input wire rst_n,
  input wire chip_enable,
  input wire chip_select_n,
  input wire read_convert,
  input wire word_byte_select,
  input wire byte_address_select,
  input wire comparator_high,
  output wire conversion_in_progress,
  output wire [`SACR_MSB:0] dac_code,
  output wire [`SACR_MSB:0] data_out,
  output wire [`SACR_MSB:0] data_oe
);

  localparam [31:0] STEP_CYC = (`SACR_STEP_NS + `SACR_CLK_NS - 1) / `SACR_CLK_NS;
  localparam [7:0] STEP_LAST = STEP_CYC[7:0] - 8'h01;
  localparam [1:0] ST_IDLE = `SACR_ST_IDLE;
  localparam [1:0] ST_CONV = `SACR_ST_CONV;
  localparam [1:0] ST_DONE = `SACR_ST_DONE;

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  reg [4:0] s1_q;
  reg [4:0] s2_q;
  reg [4:0] s3_q;
  reg [4:0] live_q;
  wire [4:0] raw_in;
  assign raw_in = {byte_address_select, word_byte_select, read_convert,
    chip_select_n, chip_enable};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_sync
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          live_q[gi] <= 1'b0;
        end
        else
        begin
          s1_q[gi] <= raw_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi])
            live_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  wire ce_l = live_q[0];
  wire cs_n_l = live_q[1];
  wire rc_l = live_q[2];
  wire wb_l = live_q[3];
  wire ba_l = live_q[4];

  // ==========================================================
  // Start detection
  // ==========================================================
  // One combined level, so any input arriving last gives the same delay
  wire start_level = ce_l & ~cs_n_l & ~rc_l;
  reg start_prev_q;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      start_prev_q <= 1'b1;
    else
      start_prev_q <= start_level;
  end
  wire start_evt = start_level & ~start_prev_q;

  // ==========================================================
  // Successive approximation sequencer
  // ==========================================================
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [3:0] bit_q;
  reg [7:0] tick_q;
  reg short_q;
  reg [`SACR_MSB:0] sar_q;
  reg [`SACR_MSB:0] result_q;
  wire step_end = (tick_q == STEP_LAST);
  wire [3:0] stop_bit = short_q ? `SACR_SHORT_STOP : `SACR_FULL_STOP;

  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (start_evt)
          state_d = ST_CONV;
      ST_CONV:
        // Starts are not looked at here
        if (step_end && bit_q == stop_bit)
          state_d = ST_DONE;
      ST_DONE:
        state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      tick_q <= 8'h00;
      short_q <= 1'b0;
      sar_q <= `SACR_ZERO12;
      result_q <= `SACR_ZERO12;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == ST_IDLE && start_evt)
      begin
        short_q <= ba_l;
        bit_q <= `SACR_TOP_BIT;
        tick_q <= 8'h00;
        sar_q <= `SACR_FIRST_TRIAL;
      end
      else if (state_q == ST_CONV)
      begin
        if (step_end)
        begin
          tick_q <= 8'h00;
          // Keep or drop the trial bit, then try the next one
          sar_q[bit_q] <= comparator_high;
          if (bit_q != stop_bit)
          begin
            bit_q <= bit_q - 4'h1;
            sar_q[bit_q - 4'h1] <= 1'b1;
          end
        end
        else
          tick_q <= tick_q + 8'h01;
      end
      else if (state_q == ST_DONE)
      begin
        if (short_q)
          result_q <= {sar_q[`SACR_MSB:4], `SACR_SHORT_FILL};
        else
          result_q <= sar_q;
      end
    end
  end

  // Status also covers the cycle that moves the result into place
  assign conversion_in_progress = (state_q != ST_IDLE);
  assign dac_code = sar_q;

  // ==========================================================
  // Output buffer control
  // ==========================================================
  wire read_ok = rc_l & ~conversion_in_progress & ce_l & ~cs_n_l;
  wire [1:0] sel_req = !read_ok ? `SACR_SEL_NONE :
    wb_l ? `SACR_SEL_WORD :
    ba_l ? `SACR_SEL_LOW : `SACR_SEL_HIGH;
  reg [1:0] sel_q;
  reg [`SACR_MSB:0] data_q;

  function [`SACR_MSB:0] sacr_enables;
    input [1:0] sel;
    begin
      case (sel)
        `SACR_SEL_WORD: sacr_enables = `SACR_HI_EN | `SACR_MID_EN | `SACR_LO_EN;
        `SACR_SEL_HIGH: sacr_enables = `SACR_HI_EN | `SACR_MID_EN;
        `SACR_SEL_LOW: sacr_enables = `SACR_MID_EN | `SACR_LO_EN;
        default: sacr_enables = `SACR_ZERO12;
      endcase
    end
  endfunction

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_q <= `SACR_SEL_NONE;
      data_q <= `SACR_ZERO12;
    end
    else
    begin
      // Between two different drive sets pass through a released cycle
      if (sel_q != `SACR_SEL_NONE && sel_req != sel_q)
        sel_q <= `SACR_SEL_NONE;
      else
        sel_q <= sel_req;
      // Byte reads hold unused lines low; the high byte is left-justified
      if (sel_req == `SACR_SEL_HIGH)
        data_q <= {result_q[`SACR_MSB:4], 4'h0};
      else if (sel_req == `SACR_SEL_LOW)
        data_q <= {8'h00, result_q[3:0]};
      else
        data_q <= result_q;
    end
  end

  // Data is already formatted for the drive set that the enables show
  assign data_out = data_q;
  assign data_oe = sacr_enables(sel_q);

endmodule // sacr_control

/* File: pkg/sacr_defines.vh */
// Constants for the converter control and readout block
`ifndef SACR_DEFINES_VH
`define SACR_DEFINES_VH
`define SACR_NBITS 12
`define SACR_MSB 11
`define SACR_TOP_BIT 4'hb
`define SACR_FIRST_TRIAL 12'h800
`define SACR_SHORT_STOP 4'h4
`define SACR_FULL_STOP 4'h0
`define SACR_STEP_NS 1000
`define SACR_CLK_NS 100
`define SACR_ST_IDLE 2'h0
`define SACR_ST_CONV 2'h1
`define SACR_ST_DONE 2'h2
`define SACR_SHORT_FILL 4'h8
`define SACR_ZERO12 12'h000
`define SACR_HI_EN 12'hf00
`define SACR_MID_EN 12'h0f0
`define SACR_LO_EN 12'h00f
`define SACR_SEL_NONE 2'h0
`define SACR_SEL_WORD 2'h1
`define SACR_SEL_HIGH 2'h2
`define SACR_SEL_LOW 2'h3
`endif

/* File: test/sacr_comp_model.sv */
// Comparator model facing the converter trial code
`timescale 1ns/1ps
module sacr_comp_model
(
  input wire [11:0] dac_code,
  input wire [11:0] analog_level,
  output wire comparator_high
);
  assign comparator_high = (dac_code <= analog_level);
endmodule // sacr_comp_model

/* File: test/sacr_checker.sv */
// Assertion checker for the converter control block
`timescale 1ns/1ps
module sacr_checker
(
  input wire clk,
  input wire rst_n,
  input wire chip_enable,
  input wire conversion_in_progress,
  input wire [11:0] dac_code,
  input wire [11:0] data_out,
  input wire [11:0] data_oe
);
  reg [7:0] high_q;
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      high_q <= 8'h00;
    else
      high_q <= conversion_in_progress ? high_q + 8'h01 : 8'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_busy_floats: assert property (conversion_in_progress |-> data_oe == 12'h000)
    else $error("buffers driven while busy");
  a_off_floats: assert property ((!chip_enable) [*8] |-> data_oe == 12'h000)
    else $error("buffers driven while disabled");
  a_oe_shape: assert property (data_oe == 12'h000 || data_oe == 12'hfff
    || data_oe == 12'hff0 || data_oe == 12'h0ff) else $error("bad enable pattern");
  a_low_byte_zero: assert property (data_oe == 12'h0ff |-> data_out[7:4] == 4'h0)
    else $error("middle lines not low");
  a_break_first: assert property (data_oe == 12'hff0 |=> data_oe != 12'h0ff)
    else $error("byte switch without break");
  a_status_span: assert property ($fell(conversion_in_progress) |->
    high_q == 8'h79 || high_q == 8'h51) else $error("wrong busy length");
  a_trial_msb: assert property ($rose(conversion_in_progress) |-> dac_code == 12'h800)
    else $error("first trial not msb");
  a_start_gated: assert property ((!chip_enable) [*8] |-> !$rose(conversion_in_progress))
    else $error("start while disabled");
endmodule // sacr_checker
bind sacr_control sacr_checker chk (.clk, .rst_n, .chip_enable, .conversion_in_progress,
  .dac_code, .data_out, .data_oe);

/* File: test/sacr_control_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module sacr_control_tb;
  reg clk = 1'b0, rst_n = 1'b0, ce = 1'b1, cs_n = 1'b0, rc = 1'b1, wbs = 1'b1, ba = 1'b0;
  reg [11:0] vin = 12'ha5c;
  wire cmp, cip;
  wire [11:0] dac, dq, oe;
  integer fail_count = 0, total_checks = 0, i;
  always #50 clk = ~clk;
  sacr_comp_model model (.dac_code(dac), .analog_level(vin), .comparator_high(cmp));
  sacr_control dut (.clk(clk), .rst_n(rst_n), .chip_enable(ce), .chip_select_n(cs_n),
    .read_convert(rc), .word_byte_select(wbs), .byte_address_select(ba),
    .comparator_high(cmp), .conversion_in_progress(cip), .dac_code(dac),
    .data_out(dq), .data_oe(oe));
  task check(input [63:0] name, input [11:0] exp, input [11:0] got);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("wrong value %0s expected %h seen %h", name, exp, got);
    end
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  // Start with input k as the last to arrive (3: all together), then a restart while busy
  task conv(input [1:0] k, input b);
  begin
    @(posedge clk);
    ce <= (k == 2'h1) || (k == 2'h2);
    cs_n <= (k == 2'h1) || (k == 2'h3);
    rc <= (k == 2'h2) || (k == 2'h3);
    ba <= b;
    repeat (8) @(posedge clk);
    ce <= 1'b1;
    cs_n <= 1'b0;
    rc <= 1'b0;
    for (i = 0; i < 20 && cip !== 1'b1; i = i + 1) @(posedge clk);
    rc <= 1'b1;
    repeat (8) @(posedge clk);
    #1 check("busy", 12'h001, {11'h000, cip});
    check("float", 12'h000, oe);
    @(posedge clk);
    rc <= 1'b0;
    repeat (8) @(posedge clk);
    rc <= 1'b1;
    for (i = 0; i < 200 && cip !== 1'b0; i = i + 1) @(posedge clk);
    #1 check("idle", 12'h000, {11'h000, cip});
  end
  endtask
  task rd(input w, input b, input [11:0] eoe, input [11:0] ed);
  begin
    @(posedge clk);
    wbs <= w;
    ba <= b;
    repeat (8) @(posedge clk);
    #1 check("enables", eoe, oe);
    check("data", ed, dq & oe);
  end
  endtask
  // Read/convert alone starts a full conversion, read as one word
  task scen_standalone;
  begin
    conv(2'h2, 1'b0);
    rd(1'b1, 1'b0, 12'hfff, 12'ha5c);
  end
  endtask
  // Select starts a short conversion, read as word and as two bytes
  task scen_short_bytes;
  begin
    vin <= 12'h3c7;
    conv(2'h1, 1'b1);
    rd(1'b1, 1'b1, 12'hfff, 12'h3c8);
    rd(1'b0, 1'b0, 12'hff0, 12'h3c0);
    rd(1'b0, 1'b1, 12'h0ff, 12'h008);
  end
  endtask
  // Enable starts a full conversion
  task scen_enable_start;
  begin
    conv(2'h0, 1'b0);
    rd(1'b1, 1'b0, 12'hfff, 12'h3c7);
  end
  endtask
  // All three start inputs change at the same edge
  task scen_all_at_once;
  begin
    conv(2'h3, 1'b0);
    rd(1'b1, 1'b0, 12'hfff, 12'h3c7);
  end
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    scen_standalone;
    scen_short_bytes;
    scen_enable_start;
    scen_all_at_once;
    end_sim;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    fail_count = fail_count + 1;
    end_sim;
  end
endmodule // sacr_control_tb
